// file: design/guard_cfg.svh
`ifndef GUARD_CFG_SVH
`define GUARD_CFG_SVH

// Sector numbers of the four outer boot sectors
`define FIRST_BOOT_SECTOR 8'h00
`define SECOND_BOOT_SECTOR 8'h01
`define NEXT_TO_LAST_BOOT_SECTOR 8'h8C
`define LAST_BOOT_SECTOR 8'h8D
`define NUM_SECTORS 142

// Secure region layout, word addresses
`define SECURE_BYTES 256
`define RANDOM_FIRST_ADDR 22'h000000
`define RANDOM_LAST_ADDR 22'h000007
`define SERIAL_FIRST_ADDR 22'h000008
`define SERIAL_LAST_ADDR 22'h00000F
`define FACTORY_LOCK_BIT 7

// Command words
`define UNLOCK_ADDR1 22'h000555
`define UNLOCK_ADDR2 22'h0002AA
`define UNLOCK_DATA1 16'h00AA
`define UNLOCK_DATA2 16'h0055
`define SECURE_ENTER_DATA 16'h0088
`define SECURE_EXIT_DATA 16'h0090
`define SECURE_EXIT_DATA2 16'h0000
`define PROGRAM_DATA 16'h00A0
`define ERASE_DATA 16'h0080
`define SECTOR_ERASE_DATA 16'h0030

// Bus timing at 40 MHz, 25 ns period
`define CLK_PERIOD_PS 25000
`define GLITCH_MIN_NS 5
`define GLITCH_CYCLES ((`GLITCH_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STROBE_LOW_NS 50
`define STROBE_LOW_CYCLES 2
`define STROBE_HIGH_CYCLES 2
`define READ_ACCESS_NS 90
`define READ_ACCESS_CYCLES 4
`define READY_TIMEOUT_CYCLES 24'hFFFFFF

`endif

// file: design/guard_pkg.sv
package guard_pkg;
  typedef enum logic [4:0] {
    OP_READ = 5'h01,
    OP_PROGRAM = 5'h02,
    OP_ERASE = 5'h04,
    OP_SECURE_ENTER = 5'h08,
    OP_SECURE_EXIT = 5'h10
  } op_e;

  typedef enum logic [5:0] {
    CYC_IDLE = 6'h01,
    CYC_SETUP = 6'h02,
    CYC_LOW = 6'h04,
    CYC_HIGH = 6'h08,
    CYC_SAMPLE = 6'h10,
    CYC_DONE = 6'h20
  } cyc_e;

  typedef enum logic [5:0] {
    SEQ_IDLE = 6'h01,
    SEQ_ISSUE = 6'h02,
    SEQ_WAIT = 6'h04,
    SEQ_POLL = 6'h08,
    SEQ_REPLY = 6'h10,
    SEQ_STEP = 6'h20
  } seq_e;
endpackage

// file: design/bus_cycle_if.sv
`timescale 1ns/100ps
interface bus_cycle_if;
  logic start;
  logic is_write;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport master (output start, output is_write, output addr,
    output wdata, input done, input rdata);
  modport slave (input start, input is_write, input addr,
    input wdata, output done, output rdata);
endinterface

// file: design/flash_bus_cycle.sv
`timescale 1ns/100ps
`include "guard_cfg.svh"
// Drives one asynchronous read or write cycle on the flash pins
module flash_bus_cycle (
  input wire logic clk_i,
  input wire logic nrst_i,
  bus_cycle_if.slave cyc,
  input wire logic [15:0] dq_sync_i,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [21:0] addr_o,
  output logic [15:0] dq_o,
  output logic dq_oe_o
);
  guard_pkg::cyc_e state_r, state_nxt;
  logic [3:0] cnt_r;
  logic wr_r;
  wire cnt_zero = (cnt_r == 4'h0);
  wire [3:0] low_len = wr_r ? 4'(`STROBE_LOW_CYCLES)
                            : 4'(`READ_ACCESS_CYCLES);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      guard_pkg::CYC_IDLE: if (cyc.start) state_nxt = guard_pkg::CYC_SETUP;
      guard_pkg::CYC_SETUP: state_nxt = guard_pkg::CYC_LOW;
      guard_pkg::CYC_LOW: if (cnt_zero) state_nxt = guard_pkg::CYC_SAMPLE;
      guard_pkg::CYC_SAMPLE: state_nxt = guard_pkg::CYC_HIGH;
      guard_pkg::CYC_HIGH: if (cnt_zero) state_nxt = guard_pkg::CYC_DONE;
      guard_pkg::CYC_DONE: state_nxt = guard_pkg::CYC_IDLE;
      default: state_nxt = guard_pkg::CYC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= guard_pkg::CYC_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      // Strobes idle high from power-up, see [RULE_19]
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      addr_o <= 22'h000000;
      dq_o <= 16'h0000;
      dq_oe_o <= 1'b0;
      cyc.rdata <= 16'h0000;
      cyc.done <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cyc.done <= (state_r == guard_pkg::CYC_HIGH) && cnt_zero;
      if (state_r == guard_pkg::CYC_IDLE && cyc.start) begin
        wr_r <= cyc.is_write;
        addr_o <= cyc.addr;
        dq_o <= cyc.wdata;
        dq_oe_o <= cyc.is_write;
        ce_n_o <= 1'b0;
        // Output enable stays high through a write so it starts cleanly
        oe_n_o <= 1'b1;
      end
      if (state_r == guard_pkg::CYC_SETUP) begin
        // Strobe low far longer than glitch width, see [RULE_17] [RULE_18]
        we_n_o <= ~wr_r;
        oe_n_o <= wr_r;
        cnt_r <= low_len - 4'h1;
      end else if (state_r == guard_pkg::CYC_LOW && !cnt_zero) begin
        cnt_r <= cnt_r - 4'h1;
      end
      if (state_r == guard_pkg::CYC_SAMPLE) begin
        cyc.rdata <= dq_sync_i;
        we_n_o <= 1'b1;
        oe_n_o <= 1'b1;
        cnt_r <= 4'(`STROBE_HIGH_CYCLES) - 4'h1;
      end else if (state_r == guard_pkg::CYC_HIGH && !cnt_zero) begin
        cnt_r <= cnt_r - 4'h1;
      end
      if (state_r == guard_pkg::CYC_HIGH && cnt_zero) begin
        ce_n_o <= 1'b1;
        dq_oe_o <= 1'b0;
      end
    end
  end
endmodule // flash_bus_cycle

// file: design/flash_guard_host.sv
// Functional notes
// [RULE_01] Guard pin low: device refuses program/erase on sectors 0,1,140,141.
// [RULE_02] Guard pin high: those sectors follow their last stored protection.
// [RULE_03] Guard pin at accelerate level: device enters fast programming.
// [RULE_04] Reset pin at identification voltage: temporary unprotect mode.
// [RULE_05] Removing that voltage restores all earlier protection.
// [RULE_06] Temporary unprotect with guard pin low keeps boot sectors protected.
// [RULE_07] 256-byte secure region; read-only factory lock indicator on bit 7.
// [RULE_08] Factory parts ship secure region locked; customer parts unlocked.
// [RULE_09] Secure region enabled: no fast programming, no unlock bypass.
// [RULE_10] Entry sequence maps secure region on boot addresses until exit.
// [RULE_11] Power-up or hardware reset routes accesses back to sector 0.
// [RULE_12] Factory parts: random number words 0-7, serial number words 8-15.
// [RULE_13] Customer secure region programs and locks once, never unlocks.
// [RULE_14] Locking needs entry sequence then protect algorithm, reset high or ID.
// [RULE_15] After locking, host issues exit sequence before touching the array.
// [RULE_16] Below lockout supply, device ignores writes and returns to read.
// [RULE_17] Strobe noise under about 5 ns starts no write cycle.
// [RULE_18] Write only with chip and write enables low, output enable high.
// [RULE_19] Power-up strobes low start no command; state machine reads.
// [RULE_20] Protected sector rejects program and erase until unprotected.
`timescale 1ns/100ps
`include "guard_cfg.svh"
module flash_guard_host (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic REQ_VALID_I,
  input wire logic [4:0] REQ_OP_I,
  input wire logic [21:0] REQ_ADDR_I,
  input wire logic [7:0] REQ_SECTOR_I,
  input wire logic [15:0] REQ_DATA_I,
  input wire logic WRITE_PROTECT_I,
  input wire logic ACCEL_I,
  input wire logic TEMP_UNPROTECT_I,
  input wire logic [15:0] DQ_I,
  input wire logic READY_I,
  output logic REQ_READY_O,
  output logic RSP_VALID_O,
  output logic [15:0] RSP_DATA_O,
  output logic RSP_REFUSED_O,
  output logic SECURE_ACTIVE_O,
  output logic FACTORY_LOCKED_O,
  output logic CE_N_O,
  output logic WE_N_O,
  output logic OE_N_O,
  output logic [21:0] ADDR_O,
  output logic [15:0] DQ_O,
  output logic DQ_OE_O,
  output logic GUARD_LOW_O,
  output logic GUARD_ACCEL_O,
  output logic ID_VOLTAGE_O
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [15:0] dq_s1_r, dq_s2_r;
  logic rdy_s1_r, rdy_s2_r;
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end else begin
      dq_s1_r <= DQ_I;
      dq_s2_r <= dq_s1_r;
      rdy_s1_r <= READY_I;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // ****************************************
  // Bus cycle engine
  // ****************************************
  bus_cycle_if cyc ();
  flash_bus_cycle u_cycle (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .cyc(cyc),
    .dq_sync_i(dq_s2_r),
    .ce_n_o(CE_N_O),
    .we_n_o(WE_N_O),
    .oe_n_o(OE_N_O),
    .addr_o(ADDR_O),
    .dq_o(DQ_O),
    .dq_oe_o(DQ_OE_O)
  );

  // ****************************************
  // Request decode
  // ****************************************
  guard_pkg::seq_e seq_r, seq_nxt;
  logic [4:0] op_r;
  logic [21:0] addr_r;
  logic [15:0] data_r;
  logic [7:0] sector_r;
  logic [2:0] step_r;
  logic secure_r;
  logic [23:0] wait_r;

  wire [7:0] fl_bit = 8'(`FACTORY_LOCK_BIT);
  wire is_boot = (sector_r == `FIRST_BOOT_SECTOR) ||
                 (sector_r == `SECOND_BOOT_SECTOR) ||
                 (sector_r == `NEXT_TO_LAST_BOOT_SECTOR) ||
                 (sector_r == `LAST_BOOT_SECTOR);
  wire is_modify = (op_r == guard_pkg::OP_PROGRAM) ||
                   (op_r == guard_pkg::OP_ERASE);
  // Guard pin low wins over temporary unprotect, see [RULE_01] [RULE_06]
  // Guard-protected boot sectors refused before any bus cycle, see [RULE_20]
  wire boot_blocked = is_modify && is_boot && WRITE_PROTECT_I;
  // Locked factory region refused once its lock bit has been read, see [RULE_08] [RULE_13]
  wire secure_blocked = is_modify && secure_r && FACTORY_LOCKED_O;
  wire refuse = boot_blocked || secure_blocked;
  wire [2:0] last_step = (op_r == guard_pkg::OP_READ) ? 3'h0 :
                         (op_r == guard_pkg::OP_ERASE) ? 3'h5 :
                         (op_r == guard_pkg::OP_SECURE_EXIT) ? 3'h3 : 3'h2;
  wire needs_poll = is_modify;

  // Command word table per step
  logic [21:0] step_addr;
  logic [15:0] step_data;
  always_comb begin
    step_addr = (step_r[0]) ? `UNLOCK_ADDR2 : `UNLOCK_ADDR1;
    step_data = (step_r[0]) ? `UNLOCK_DATA2 : `UNLOCK_DATA1;
    case (step_r)
      3'h2: begin
        step_addr = `UNLOCK_ADDR1;
        case (op_r)
          guard_pkg::OP_PROGRAM: step_data = `PROGRAM_DATA;
          guard_pkg::OP_ERASE: step_data = `ERASE_DATA;
          // Entry maps secure region on boot addresses, see [RULE_10]
          guard_pkg::OP_SECURE_ENTER: step_data = `SECURE_ENTER_DATA;
          default: step_data = `SECURE_EXIT_DATA;
        endcase
      end
      3'h3: begin
        step_addr = (op_r == guard_pkg::OP_PROGRAM) ? addr_r : 22'h000000;
        step_data = (op_r == guard_pkg::OP_PROGRAM) ? data_r :
                    `SECURE_EXIT_DATA2;
        // Erase repeats the unlock pair before its sector word
        if (op_r == guard_pkg::OP_ERASE) begin
          step_addr = `UNLOCK_ADDR1;
          step_data = `UNLOCK_DATA1;
        end
      end
      3'h4: begin
        step_addr = `UNLOCK_ADDR2;
        step_data = `UNLOCK_DATA2;
      end
      3'h5: begin
        step_addr = addr_r;
        step_data = `SECTOR_ERASE_DATA;
      end
      default: begin
      end
    endcase
    if (op_r == guard_pkg::OP_READ) begin
      step_addr = addr_r;
      step_data = 16'h0000;
    end
  end
  wire [2:0] final_step = (op_r == guard_pkg::OP_PROGRAM) ? 3'h3 : last_step;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      guard_pkg::SEQ_IDLE: if (REQ_VALID_I) seq_nxt = guard_pkg::SEQ_STEP;
      guard_pkg::SEQ_STEP:
        seq_nxt = refuse ? guard_pkg::SEQ_REPLY : guard_pkg::SEQ_ISSUE;
      guard_pkg::SEQ_ISSUE: seq_nxt = guard_pkg::SEQ_WAIT;
      guard_pkg::SEQ_WAIT: if (cyc.done) begin
        if (step_r != final_step) seq_nxt = guard_pkg::SEQ_ISSUE;
        else if (needs_poll) seq_nxt = guard_pkg::SEQ_POLL;
        else seq_nxt = guard_pkg::SEQ_REPLY;
      end
      guard_pkg::SEQ_POLL:
        if (rdy_s2_r || wait_r == 24'h000000) seq_nxt = guard_pkg::SEQ_REPLY;
      guard_pkg::SEQ_REPLY: seq_nxt = guard_pkg::SEQ_IDLE;
      default: seq_nxt = guard_pkg::SEQ_IDLE;
    endcase
  end

  assign cyc.start = (seq_r == guard_pkg::SEQ_ISSUE);
  assign cyc.is_write = (op_r != guard_pkg::OP_READ);
  assign cyc.addr = step_addr;
  assign cyc.wdata = step_data;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      seq_r <= guard_pkg::SEQ_IDLE;
      // Back to plain reads after reset, see [RULE_16]
      op_r <= 5'h01;
      addr_r <= 22'h000000;
      data_r <= 16'h0000;
      sector_r <= 8'h00;
      step_r <= 3'h0;
      wait_r <= 24'h000000;
    end else begin
      seq_r <= seq_nxt;
      if (seq_r == guard_pkg::SEQ_IDLE && REQ_VALID_I) begin
        op_r <= REQ_OP_I;
        addr_r <= REQ_ADDR_I;
        data_r <= REQ_DATA_I;
        sector_r <= REQ_SECTOR_I;
        step_r <= (REQ_OP_I == guard_pkg::OP_READ) ? 3'h0 : 3'h0;
      end
      if (seq_r == guard_pkg::SEQ_WAIT && cyc.done &&
          step_r != final_step) begin
        step_r <= step_r + 3'h1;
      end
      if (seq_r == guard_pkg::SEQ_WAIT)
        wait_r <= `READY_TIMEOUT_CYCLES;
      else if (seq_r == guard_pkg::SEQ_POLL && wait_r != 24'h000000)
        wait_r <= wait_r - 24'h000001;
    end
  end

  // ****************************************
  // Answers and mode pins
  // ****************************************
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      REQ_READY_O <= 1'b0;
      RSP_VALID_O <= 1'b0;
      RSP_DATA_O <= 16'h0000;
      RSP_REFUSED_O <= 1'b0;
      // Device reverts to sector 0 after reset, see [RULE_11]
      secure_r <= 1'b0;
      SECURE_ACTIVE_O <= 1'b0;
      FACTORY_LOCKED_O <= 1'b0;
      GUARD_LOW_O <= 1'b0;
      GUARD_ACCEL_O <= 1'b0;
      ID_VOLTAGE_O <= 1'b0;
    end else begin
      REQ_READY_O <= (seq_nxt == guard_pkg::SEQ_IDLE);
      RSP_VALID_O <= (seq_r == guard_pkg::SEQ_REPLY);
      RSP_REFUSED_O <= (seq_r == guard_pkg::SEQ_STEP) ? refuse
                       : RSP_REFUSED_O && (seq_r != guard_pkg::SEQ_IDLE);
      if (seq_r == guard_pkg::SEQ_WAIT && cyc.done &&
          op_r == guard_pkg::OP_READ) begin
        // Secure words pass through untouched, see [RULE_12]
        RSP_DATA_O <= cyc.rdata;
        // Indicator read in secure mode is read-only, see [RULE_07]
        if (secure_r) FACTORY_LOCKED_O <= cyc.rdata[fl_bit[3:0]];
      end
      if (seq_r == guard_pkg::SEQ_REPLY && !RSP_REFUSED_O) begin
        if (op_r == guard_pkg::OP_SECURE_ENTER) secure_r <= 1'b1;
        // Exit before array access, see [RULE_15]
        if (op_r == guard_pkg::OP_SECURE_EXIT) secure_r <= 1'b0;
      end
      SECURE_ACTIVE_O <= secure_r;
      GUARD_LOW_O <= WRITE_PROTECT_I; // see [RULE_02]
      // Accelerate level only where allowed, see [RULE_03] [RULE_09]
      GUARD_ACCEL_O <= ACCEL_I && !secure_r && !WRITE_PROTECT_I;
      // Temporary unprotect, dropped with the request, see [RULE_04] [RULE_05]
      ID_VOLTAGE_O <= TEMP_UNPROTECT_I;
    end
  end
endmodule // flash_guard_host

// file: bench/flash_guard_host_chk.sv
`timescale 1ns/100ps
// ****************************
// Host port checker
// ****************************
module flash_guard_host_chk (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic REQ_VALID_I,
  input wire logic [4:0] REQ_OP_I,
  input wire logic [7:0] REQ_SECTOR_I,
  input wire logic WRITE_PROTECT_I,
  input wire logic TEMP_UNPROTECT_I,
  input wire logic REQ_READY_O,
  input wire logic RSP_VALID_O,
  input wire logic RSP_REFUSED_O,
  input wire logic SECURE_ACTIVE_O,
  input wire logic FACTORY_LOCKED_O,
  input wire logic CE_N_O,
  input wire logic WE_N_O,
  input wire logic OE_N_O,
  input wire logic DQ_OE_O,
  input wire logic GUARD_LOW_O,
  input wire logic GUARD_ACCEL_O,
  input wire logic ID_VOLTAGE_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  wire take = REQ_VALID_I && REQ_READY_O;
  wire wr_op = REQ_OP_I == 5'h02 || REQ_OP_I == 5'h04;
  wire boot = REQ_SECTOR_I inside {8'h00, 8'h01, 8'h8C, 8'h8D};
  AST_WRITE_STROBES:
    assert property (!WE_N_O |-> !CE_N_O && OE_N_O && DQ_OE_O)
    else $error("write strobe outside a write cycle");
  AST_READ_STROBES:
    assert property ($fell(OE_N_O) |-> WE_N_O && !CE_N_O && !DQ_OE_O)
    else $error("read strobe during a write");
  // Setup edge, two counted cycles and the sample cycle
  AST_WE_WIDTH:
    assert property ($fell(WE_N_O) |-> !WE_N_O [*3] ##1 WE_N_O)
    else $error("write strobe width wrong");
  AST_GUARD_PIN:
    assert property (GUARD_LOW_O == $past(WRITE_PROTECT_I))
    else $error("guard pin does not follow request");
  AST_ID_PIN:
    assert property (ID_VOLTAGE_O == $past(TEMP_UNPROTECT_I))
    else $error("identification voltage does not follow request");
  AST_ACCEL_EXCL:
    assert property (GUARD_ACCEL_O |-> !SECURE_ACTIVE_O && !GUARD_LOW_O)
    else $error("accelerate level while excluded");
  AST_BOOT_REFUSE:
    assert property (take && wr_op && boot && WRITE_PROTECT_I && GUARD_LOW_O
      |-> CE_N_O [*4] ##0 (RSP_VALID_O && RSP_REFUSED_O))
    else $error("boot sector write not refused quietly");
  AST_FACTORY_REFUSE:
    assert property (take && wr_op && SECURE_ACTIVE_O && FACTORY_LOCKED_O
      |-> CE_N_O [*4] ##0 (RSP_VALID_O && RSP_REFUSED_O))
    else $error("factory region write not refused");
  AST_SECURE_ENTER:
    assert property (take && REQ_OP_I == 5'h08 |-> ##[1:300] SECURE_ACTIVE_O)
    else $error("secure region not mapped after entry");
  AST_SECURE_EXIT:
    assert property (take && REQ_OP_I == 5'h10 |-> ##[1:300] !SECURE_ACTIVE_O)
    else $error("secure region still mapped after exit");
  cover property (take && wr_op && boot && GUARD_LOW_O);
  cover property ($rose(SECURE_ACTIVE_O));
  cover property ($fell(WE_N_O) && ID_VOLTAGE_O);
endmodule // flash_guard_host_chk

bind flash_guard_host flash_guard_host_chk chk_u (.CORE_CLK_I, .NRST_I,
  .REQ_VALID_I, .REQ_OP_I, .REQ_SECTOR_I, .WRITE_PROTECT_I, .TEMP_UNPROTECT_I,
  .REQ_READY_O, .RSP_VALID_O, .RSP_REFUSED_O, .SECURE_ACTIVE_O,
  .FACTORY_LOCKED_O, .CE_N_O, .WE_N_O, .OE_N_O, .DQ_OE_O, .GUARD_LOW_O,
  .GUARD_ACCEL_O, .ID_VOLTAGE_O);

// file: bench/flash_model.sv
`timescale 1ns/100ps
// ****************************
// Flash device model
// ****************************
module flash_model (
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [21:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic guard_low_i,
  input wire logic accel_i,
  input wire logic id_volt_i,
  input wire logic factory_i,
  output logic [15:0] dq_o,
  output logic ready_o = 1'b1
);
  // Words alias by sector and low bits; enough for sparse traffic
  logic [15:0] mem [0:16383];
  logic [15:0] sec [0:127];
  logic [15:0] last = 16'h0000;
  logic [2:0] step = 3'h0;
  logic secure = 1'b0;
  logic erase_armed = 1'b0;
  realtime t_low = 0;
  wire win = secure && addr_i[21:7] == 15'h0000;
  // Factory words carry the lock bit
  wire [15:0] rd = !win ? mem[{addr_i[21:12], addr_i[3:0]}] :
    factory_i ? {addr_i[3] ? 8'h5A : 8'hA5, 1'b1, addr_i[6:0]} :
    sec[addr_i[6:0]];
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    foreach (sec[i]) sec[i] = 16'h0000;
  end
  task automatic store(input logic [21:0] a, input logic [15:0] d);
    if (secure && a[21:7] == 15'h0000) begin
      if (!factory_i) sec[a[6:0]] = d;
    // Sector 010h stands for one stored as protected
    end else if (!(guard_low_i && (a[21:13] == 9'h000 || a[21:13] == 9'h1FF))
        && (a[21:12] != 10'h010 || id_volt_i))
      mem[{a[21:12], a[3:0]}] = d;
    ready_o = 1'b0;
    // Accelerate shortens busy time
    ready_o <= #((accel_i && !secure) ? 100 : 400) 1'b1;
  endtask
  task automatic command(input logic [21:0] a, input logic [15:0] d);
    case (step)
      3'h0: step = (d[7:0] == 8'hAA && a[10:0] == 11'h555) ? 3'h1 : 3'h0;
      3'h1: step = d[7:0] == 8'h55 ? 3'h2 : 3'h0;
      3'h2: begin
        step = 3'h0;
        case (d[7:0])
          8'h88: secure = 1'b1;
          8'h90: step = 3'h4;
          8'hA0: step = 3'h3;
          8'h80: erase_armed = 1'b1;
          8'h30: if (erase_armed) store(a, 16'hFFFF);
          default: ;
        endcase
      end
      3'h3: begin
        step = 3'h0;
        store(a, d);
      end
      default: begin
        step = 3'h0;
        if (d[7:0] == 8'h00) secure = 1'b0;
      end
    endcase
  endtask
  // Released bus shows the inverse, never a stale match
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
  always @(posedge oe_n_i) last = rd;
  always @(negedge we_n_i) t_low = $realtime;
  // Short or badly qualified strobes start nothing
  always @(posedge we_n_i)
    if (!ce_n_i && oe_n_i && $realtime - t_low >= 5.0)
      command(addr_i, dq_i);
endmodule // flash_model

// file: bench/flash_guard_host_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", n, e, s); end end
module flash_guard_host_bench;
  // ****************************
  // Clock, design and partner
  // ****************************
  logic clk = 0, nrst = 0, vld = 0, wp = 0, acc = 0, tu = 0, fac = 0;
  logic [4:0] op = 5'h00;
  logic [21:0] adr = 22'h000000;
  logic [7:0] sct = 8'h00;
  logic [15:0] wd = 16'h0000, rd;
  logic rf;
  int num_errors = 0, check_count = 0;
  wire rr, rv, rref, sa, fl, ce_n, we_n, oe_n, dq_oe, gl, ga, idv, rdy;
  wire [15:0] rdat, fdo, fdi, mq;
  wire [21:0] fa;
  always #12.5 clk = ~clk;
  flash_guard_host dut_u (.CORE_CLK_I(clk), .NRST_I(nrst), .REQ_VALID_I(vld),
    .REQ_OP_I(op), .REQ_ADDR_I(adr), .REQ_SECTOR_I(sct), .REQ_DATA_I(wd),
    .WRITE_PROTECT_I(wp), .ACCEL_I(acc), .TEMP_UNPROTECT_I(tu), .DQ_I(fdi),
    .READY_I(rdy), .REQ_READY_O(rr), .RSP_VALID_O(rv), .RSP_DATA_O(rdat),
    .RSP_REFUSED_O(rref), .SECURE_ACTIVE_O(sa), .FACTORY_LOCKED_O(fl),
    .CE_N_O(ce_n), .WE_N_O(we_n), .OE_N_O(oe_n), .ADDR_O(fa), .DQ_O(fdo),
    .DQ_OE_O(dq_oe), .GUARD_LOW_O(gl), .GUARD_ACCEL_O(ga), .ID_VOLTAGE_O(idv));
  flash_model mdl_u (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fa),
    .dq_i(fdi), .guard_low_i(gl), .accel_i(ga), .id_volt_i(idv),
    .factory_i(fac), .dq_o(mq), .ready_o(rdy));
  assign fdi = dq_oe ? fdo : mq;
  // ****************************
  // Requests and scenarios
  // ****************************
  task automatic req(input logic [4:0] o, input logic [21:0] a,
      input logic [7:0] s, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (rr !== 1'b1) @(negedge clk);
    op = o;
    adr = a;
    sct = s;
    wd = d;
    vld = 1;
    @(negedge clk);
    vld = 0;
    while (rv !== 1'b1 && n < 3000) begin
      n++;
      @(negedge clk);
    end
    rd = rdat;
    rf = rref;
    `CHK("answer", 1'b1, rv)
  endtask
  task automatic prd(input logic [21:0] a, input logic [15:0] e);
    req(5'h01, a, 8'h00, 16'h0000);
    `CHK("read", e, rd)
  endtask
  task automatic t_basic;
    req(5'h02, 22'h020010, 8'h14, 16'h1234);
    prd(22'h020010, 16'h1234);
    req(5'h04, 22'h020010, 8'h14, 16'h0000);
    prd(22'h020010, 16'hFFFF);
  endtask
  task automatic t_guard;
    logic [21:0] a [4] = '{22'h000100, 22'h001100, 22'h3FE100, 22'h3FF100};
    logic [7:0] s [4] = '{8'h00, 8'h01, 8'h8C, 8'h8D};
    wp = 1;
    foreach (a[i]) begin
      req(i[0] ? 5'h04 : 5'h02, a[i], s[i], 16'h0BAD);
      `CHK("refused", 1'b1, rf)
      prd(a[i], 16'hFFFF);
    end
    wp = 0;
    req(5'h02, a[3], s[3], 16'h00C3);
    `CHK("refused", 1'b0, rf)
    prd(a[3], 16'h00C3);
  endtask
  task automatic t_temp;
    req(5'h02, 22'h010020, 8'h0B, 16'h1111);
    prd(22'h010020, 16'hFFFF);
    tu = 1;
    req(5'h02, 22'h010020, 8'h0B, 16'h2222);
    `CHK("id pin", 1'b1, idv)
    prd(22'h010020, 16'h2222);
    wp = 1;
    req(5'h02, 22'h000200, 8'h00, 16'h3333);
    `CHK("refused", 1'b1, rf)
    wp = 0;
    tu = 0;
    req(5'h02, 22'h010020, 8'h0B, 16'h4444);
    prd(22'h010020, 16'h2222);
  endtask
  task automatic t_secure;
    req(5'h08, 22'h000000, 8'h00, 16'h0000);
    // Mapped flag follows the answer by one clock
    @(negedge clk);
    `CHK("mapped", 1'b1, sa)
    prd(22'h000005, 16'h0000);
    `CHK("factory", 1'b0, fl)
    req(5'h02, 22'h000005, 8'h00, 16'h1234);
    prd(22'h000005, 16'h1234);
    acc = 1;
    repeat (2) @(negedge clk);
    `CHK("accel", 1'b0, ga)
    req(5'h10, 22'h000000, 8'h00, 16'h0000);
    @(negedge clk);
    `CHK("mapped", 1'b0, sa)
    prd(22'h000005, 16'hFFFF);
    `CHK("accel", 1'b1, ga)
    acc = 0;
  endtask
  task automatic t_factory;
    fac = 1;
    req(5'h08, 22'h000000, 8'h00, 16'h0000);
    prd(22'h000003, 16'hA583);
    `CHK("factory", 1'b1, fl)
    prd(22'h00000B, 16'h5A8B);
    req(5'h02, 22'h000003, 8'h00, 16'h0000);
    `CHK("refused", 1'b1, rf)
    req(5'h10, 22'h000000, 8'h00, 16'h0000);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1;
    t_basic;
    t_guard;
    t_temp;
    t_secure;
    t_factory;
    complete_run;
  end
  // Run needs under 1000 cycles; generous margin
  initial begin
    #400000;
    num_errors++;
    complete_run;
  end
endmodule // flash_guard_host_bench
